/* pcva_pkg.sv */
// constants and types for the port configuration and virtual port alias block
package pcva_pkg;
    localparam int NUM_PORTS = 16;
    localparam int NUM_PINS = 8;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // address regions (byte addresses, one 32-bit word per register)
    localparam logic [3:0] CFG_REGION = 4'h8;
    localparam logic [3:0] VP_REGION = 4'h9;

    // physical port register indexes, byte address = 4 * index
    localparam logic [4:0] IDX_DIR = 5'h00;
    localparam logic [4:0] IDX_OUT = 5'h04;
    localparam logic [4:0] IDX_IN = 5'h08;
    localparam logic [4:0] IDX_SRC0 = 5'h0a;
    localparam logic [4:0] IDX_SRC1 = 5'h0b;
    localparam logic [4:0] IDX_FLAGS = 5'h0c;
    localparam logic [1:0] IDX_SETUP_HI = 2'b10;

    // configuration register indexes
    localparam logic [2:0] CFG_IDX_MASK = 3'h0;
    localparam logic [2:0] CFG_IDX_MAP_A = 3'h2;
    localparam logic [2:0] CFG_IDX_MAP_B = 3'h3;
    localparam logic [2:0] CFG_IDX_ROUTE = 3'h4;

    // virtual port register indexes
    localparam logic [1:0] VP_IDX_DIR = 2'h0;
    localparam logic [1:0] VP_IDX_OUT = 2'h1;
    localparam logic [1:0] VP_IDX_IN = 2'h2;
    localparam logic [1:0] VP_IDX_FLAGS = 2'h3;

    // route register layout
    localparam int ROUTE_EV_LSB = 4;
    localparam int ROUTE_CLK_LSB = 0;
    localparam logic [7:0] ROUTE_RSVD_ONES = 8'hcc;
    localparam logic [1:0] ROUTE_OFF = 2'h0;
    localparam int ROUTED_PIN = 7;
    localparam int FIRST_ROUTED_PORT = 2;
    localparam int LAST_ROUTED_PORT = 4;

    // sense field of a per-pin setup register
    localparam int SENSE_LSB = 0;
    localparam logic [2:0] SENSE_BOTH = 3'h0;
    localparam logic [2:0] SENSE_RISE = 3'h1;
    localparam logic [2:0] SENSE_FALL = 3'h2;
    localparam logic [2:0] SENSE_LOW = 3'h3;
    localparam logic [2:0] SENSE_OFF = 3'h7;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_FLAGS = 2'h0;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] out;
        logic [7:0] src0;
        logic [7:0] src1;
        logic [1:0] flags;
    } pcva_port_t;

    typedef struct packed {
        logic [3:0] sel_hi;
        logic [3:0] sel_lo;
    } pcva_map_t;
endpackage

/* pcva_port_cfg.sv */
// port configuration, virtual port alias and clock/event pin routing with apb access
//
// Notes on behaviour
// - each set bit of multi_pin_select adds that pin to the broadcast group
// - a per_pin_setup write is copied to every selected pin of that port
// - broadcast happens even when the addressed pin is not selected
// - any per_pin_setup write clears multi_pin_select to zero
// - alias_map_ctrl_a: alias1 selector bits 7:4, alias0 bits 3:0, reset zero
// - alias_map_ctrl_b: alias3 selector bits 7:4, alias2 bits 3:0
// - virtual direction, output, input, flag accesses act on the selected port
// - selector codes 0 to 15 pick ports a through p in order
// - route register bits 7:6 and 3:2 read one; software writes zero
// - event route bits 5:4: off, port c, d, e pin 7
// - clock route bits 1:0: off, port c, d, e pin 7
// - clock wins when both routes pick the same pin
// - routed signal reaches pin 7 only when that pin is an output
// - input register shows pin levels only while input buffer is enabled
// - virtual flag bits 7:2 read zero; software writes zero
// - pin_change_flag n sets on sensed change of a source pin; write one clears
// - sense_select: both edges, rising, falling, low level
// - pin is a source of interrupt n only when its select bit is one
`timescale 1ns/1ps
`default_nettype none

module pcva_port_cfg (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcva_pkg::ADDR_W-1:0] paddr,
    input wire logic [pcva_pkg::DATA_W-1:0] pwdata,
    output logic [pcva_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pcva_pkg::NUM_PORTS-1:0][7:0] pin_in,
    input wire logic event_ch0,
    output logic [pcva_pkg::NUM_PORTS-1:0][7:0] pin_out,
    output logic [pcva_pkg::NUM_PORTS-1:0][7:0] pin_oe_n
);

    // sense decode, one bit per pin
    function automatic logic [7:0] sense_hits(
        input logic [7:0][7:0] setup,
        input logic [7:0] cur,
        input logic [7:0] prev
    );
        logic [7:0] hits;
        logic [2:0] mode;
        hits = 8'h00;
        mode = 3'h0;
        for (int k = 0; k < pcva_pkg::NUM_PINS; k++) begin
            mode = setup[k][pcva_pkg::SENSE_LSB +: 3];
            unique case (mode)
                pcva_pkg::SENSE_BOTH: hits[k] = cur[k] ^ prev[k];
                pcva_pkg::SENSE_RISE: hits[k] = cur[k] & ~prev[k];
                pcva_pkg::SENSE_FALL: hits[k] = ~cur[k] & prev[k];
                pcva_pkg::SENSE_LOW: hits[k] = ~cur[k];
                default: hits[k] = 1'b0;
            endcase
        end
        return hits;
    endfunction

    // route code that names a port, zero for ports that cannot be routed
    function automatic logic [1:0] route_code(input int p);
        if (p >= pcva_pkg::FIRST_ROUTED_PORT && p <= pcva_pkg::LAST_ROUTED_PORT) begin
            return 2'(p - 1);
        end
        return pcva_pkg::ROUTE_OFF;
    endfunction

    pcva_pkg::pcva_port_t regs [pcva_pkg::NUM_PORTS];
    logic [pcva_pkg::NUM_PORTS-1:0][7:0][7:0] pin_setup;
    logic [pcva_pkg::NUM_PORTS-1:0][7:0] sampled;
    logic [pcva_pkg::NUM_PORTS-1:0][7:0] sampled_prev;
    logic [7:0] multi_pin_select;
    pcva_pkg::pcva_map_t alias_map_ctrl_a;
    pcva_pkg::pcva_map_t alias_map_ctrl_b;
    logic [1:0] event_pin_route_sel;
    logic [1:0] clock_pin_route_sel;
    logic clk_half;

    // bus phases
    wire setup_phase = psel & ~penable;
    wire write_en = psel & penable & pready & pwrite;

    // address decode
    wire is_phys = ~paddr[11];
    wire [3:0] phys_port = paddr[10:7];
    wire [4:0] phys_idx = paddr[6:2];
    wire is_cfg = (paddr[11:8] == pcva_pkg::CFG_REGION) && (paddr[7:5] == 3'h0);
    wire [2:0] cfg_idx = paddr[4:2];
    wire is_vp = (paddr[11:8] == pcva_pkg::VP_REGION) && (paddr[7:6] == 2'h0);
    wire [1:0] vp_num = paddr[5:4];
    wire [1:0] vp_idx = paddr[3:2];

    // alias selector per virtual port
    wire [3:0] alias0_port_select = alias_map_ctrl_a.sel_lo;
    wire [3:0] alias1_port_select = alias_map_ctrl_a.sel_hi;
    wire [3:0] alias2_port_select = alias_map_ctrl_b.sel_lo;
    wire [3:0] alias3_port_select = alias_map_ctrl_b.sel_hi;
    wire [3:0] alias_port_select = (vp_num == 2'h0) ? alias0_port_select :
                                   (vp_num == 2'h1) ? alias1_port_select :
                                   (vp_num == 2'h2) ? alias2_port_select : alias3_port_select;

    // virtual index to physical index
    wire [4:0] vp_as_idx = (vp_idx == pcva_pkg::VP_IDX_DIR) ? pcva_pkg::IDX_DIR :
                           (vp_idx == pcva_pkg::VP_IDX_OUT) ? pcva_pkg::IDX_OUT :
                           (vp_idx == pcva_pkg::VP_IDX_IN) ? pcva_pkg::IDX_IN : pcva_pkg::IDX_FLAGS;

    // one access path for physical and aliased accesses, code selects port directly
    wire [3:0] tgt_port = is_phys ? phys_port : alias_port_select;
    wire [4:0] tgt_idx = is_phys ? phys_idx : vp_as_idx;
    wire tgt_is_setup = tgt_idx[4:3] == pcva_pkg::IDX_SETUP_HI;
    wire tgt_known = tgt_is_setup || tgt_idx == pcva_pkg::IDX_DIR || tgt_idx == pcva_pkg::IDX_OUT ||
                     tgt_idx == pcva_pkg::IDX_IN || tgt_idx == pcva_pkg::IDX_SRC0 ||
                     tgt_idx == pcva_pkg::IDX_SRC1 || tgt_idx == pcva_pkg::IDX_FLAGS;
    wire tgt_valid = (is_phys & tgt_known) | is_vp;
    wire cfg_valid = is_cfg && (cfg_idx == pcva_pkg::CFG_IDX_MASK || cfg_idx == pcva_pkg::CFG_IDX_MAP_A ||
                                cfg_idx == pcva_pkg::CFG_IDX_MAP_B || cfg_idx == pcva_pkg::CFG_IDX_ROUTE);
    wire mapped = tgt_valid | cfg_valid;

    // write strobes
    wire cfg_wr = write_en & cfg_valid;
    wire setup_wr = write_en & tgt_valid & tgt_is_setup;

    // visible input levels
    logic [pcva_pkg::NUM_PORTS-1:0][7:0] in_vis;

    // read selection
    pcva_pkg::pcva_port_t sel_regs;
    assign sel_regs = regs[tgt_port];
    wire [7:0] sel_setup = pin_setup[tgt_port][tgt_idx[2:0]];
    wire [7:0] route_rd = pcva_pkg::ROUTE_RSVD_ONES |
                          {2'b00, event_pin_route_sel, 2'b00, clock_pin_route_sel};
    wire [7:0] port_rd = tgt_is_setup ? sel_setup :
                         (tgt_idx == pcva_pkg::IDX_DIR) ? sel_regs.dir :
                         (tgt_idx == pcva_pkg::IDX_OUT) ? sel_regs.out :
                         (tgt_idx == pcva_pkg::IDX_IN) ? in_vis[tgt_port] :
                         (tgt_idx == pcva_pkg::IDX_SRC0) ? sel_regs.src0 :
                         (tgt_idx == pcva_pkg::IDX_SRC1) ? sel_regs.src1 :
                         {6'h00, sel_regs.flags};
    wire [7:0] cfg_rd = (cfg_idx == pcva_pkg::CFG_IDX_MASK) ? multi_pin_select :
                        (cfg_idx == pcva_pkg::CFG_IDX_MAP_A) ? alias_map_ctrl_a :
                        (cfg_idx == pcva_pkg::CFG_IDX_MAP_B) ? alias_map_ctrl_b : route_rd;
    wire [7:0] rd_byte = tgt_valid ? port_rd : cfg_valid ? cfg_rd : 8'h00;

    // configuration next values
    wire [7:0] next_multi_pin_select = setup_wr ? pcva_pkg::RESET_BYTE :
                                       (cfg_wr && cfg_idx == pcva_pkg::CFG_IDX_MASK) ? pwdata[7:0] :
                                       multi_pin_select;
    wire [7:0] next_map_a = (cfg_wr && cfg_idx == pcva_pkg::CFG_IDX_MAP_A) ? pwdata[7:0] : alias_map_ctrl_a;
    wire [7:0] next_map_b = (cfg_wr && cfg_idx == pcva_pkg::CFG_IDX_MAP_B) ? pwdata[7:0] : alias_map_ctrl_b;
    wire route_wr = cfg_wr && cfg_idx == pcva_pkg::CFG_IDX_ROUTE;
    wire [1:0] next_event_route = route_wr ? pwdata[pcva_pkg::ROUTE_EV_LSB +: 2] : event_pin_route_sel;
    wire [1:0] next_clock_route = route_wr ? pwdata[pcva_pkg::ROUTE_CLK_LSB +: 2] : clock_pin_route_sel;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            multi_pin_select <= pcva_pkg::RESET_BYTE;
            alias_map_ctrl_a <= pcva_pkg::RESET_BYTE;
            alias_map_ctrl_b <= pcva_pkg::RESET_BYTE;
            event_pin_route_sel <= pcva_pkg::ROUTE_OFF;
            clock_pin_route_sel <= pcva_pkg::ROUTE_OFF;
            clk_half <= 1'b0;
        end else begin
            multi_pin_select <= next_multi_pin_select;
            alias_map_ctrl_a <= next_map_a;
            alias_map_ctrl_b <= next_map_b;
            event_pin_route_sel <= next_event_route;
            clock_pin_route_sel <= next_clock_route;
            clk_half <= ~clk_half;
        end
    end

    // apb answer: computed in setup, so access completes in its first cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & ~mapped;
            prdata <= setup_phase ? {24'h000000, rd_byte} : prdata;
        end
    end

    // per-port logic
    for (genvar p = 0; p < pcva_pkg::NUM_PORTS; p++) begin : g_port
        wire wr_port = write_en & tgt_valid & (tgt_port == 4'(p));
        pcva_pkg::pcva_port_t next_regs;
        logic [7:0] next_pin_out;
        wire [7:0] hits = sense_hits(pin_setup[p], sampled[p], sampled_prev[p]);
        wire set0 = |(hits & regs[p].src0);
        wire set1 = |(hits & regs[p].src1);
        wire [1:0] clr = (wr_port && tgt_idx == pcva_pkg::IDX_FLAGS) ? pwdata[1:0] : 2'b00;
        wire clk_hit = route_code(p) != pcva_pkg::ROUTE_OFF && clock_pin_route_sel == route_code(p);
        wire ev_hit = route_code(p) != pcva_pkg::ROUTE_OFF && event_pin_route_sel == route_code(p);
        wire pin7_out = regs[p].dir[pcva_pkg::ROUTED_PIN];

        for (genvar k = 0; k < pcva_pkg::NUM_PINS; k++) begin : g_pin
            // addressed pin or any selected pin takes the written value
            wire hit = wr_port && tgt_is_setup && (tgt_idx[2:0] == 3'(k) || multi_pin_select[k]);
            wire [7:0] next_setup = hit ? pwdata[7:0] : pin_setup[p][k];
            wire buf_on = pin_setup[p][k][pcva_pkg::SENSE_LSB +: 3] != pcva_pkg::SENSE_OFF;
            assign in_vis[p][k] = sampled[p][k] & buf_on;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_setup[p][k] <= pcva_pkg::RESET_BYTE;
                end else begin
                    pin_setup[p][k] <= next_setup;
                end
            end
        end

        assign next_regs.dir = (wr_port && tgt_idx == pcva_pkg::IDX_DIR) ? pwdata[7:0] : regs[p].dir;
        assign next_regs.out = (wr_port && tgt_idx == pcva_pkg::IDX_OUT) ? pwdata[7:0] : regs[p].out;
        assign next_regs.src0 = (wr_port && tgt_idx == pcva_pkg::IDX_SRC0) ? pwdata[7:0] : regs[p].src0;
        assign next_regs.src1 = (wr_port && tgt_idx == pcva_pkg::IDX_SRC1) ? pwdata[7:0] : regs[p].src1;
        // set wins over a clear in the same cycle
        assign next_regs.flags = (regs[p].flags & ~clr) | {set1, set0};

        // pin 7 carries the routed clock or event, clock first
        always_comb begin
            next_pin_out = regs[p].out;
            if (pin7_out && clk_hit) begin
                next_pin_out[pcva_pkg::ROUTED_PIN] = clk_half;
            end else if (pin7_out && ev_hit) begin
                next_pin_out[pcva_pkg::ROUTED_PIN] = event_ch0;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                regs[p] <= '0;
                sampled[p] <= pcva_pkg::RESET_BYTE;
                sampled_prev[p] <= pcva_pkg::RESET_BYTE;
                pin_out[p] <= pcva_pkg::RESET_BYTE;
                pin_oe_n[p] <= 8'hff;
            end else begin
                regs[p] <= next_regs;
                sampled[p] <= pin_in[p];
                sampled_prev[p] <= sampled[p];
                pin_out[p] <= next_pin_out;
                pin_oe_n[p] <= ~next_regs.dir;
            end
        end
    end

endmodule // pcva_port_cfg

`default_nettype wire

/* pcva_port_cfg_chk.sv */
// concurrent checks for the port configuration and alias block
`timescale 1ns/1ps
`default_nettype none
module pcva_port_cfg_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcva_pkg::ADDR_W-1:0] paddr,
    input wire logic [pcva_pkg::DATA_W-1:0] pwdata,
    input wire logic [pcva_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [pcva_pkg::NUM_PORTS-1:0][7:0] pin_in,
    input wire logic event_ch0,
    input wire logic [pcva_pkg::NUM_PORTS-1:0][7:0] pin_out,
    input wire logic [pcva_pkg::NUM_PORTS-1:0][7:0] pin_oe_n
);
    logic [1:0] ev;
    logic [1:0] ck;
    wire done = psel && penable && pready;
    wire wr_done = done && pwrite;
    wire rd_done = done && !pwrite;
    wire [3:0] ev_port = {2'b00, ev} + 4'h1;
    wire [3:0] ck_port = {2'b00, ck} + 4'h1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev <= 2'h0;
            ck <= 2'h0;
        end else if (wr_done && paddr[11:2] == 10'h204) begin
            ev <= pwdata[5:4];
            ck <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup_wr;
        wr_done && !paddr[11] && paddr[6:5] == 2'b10;
    endsequence
    sequence s_mask_rd;
        psel && !penable && !pwrite && paddr[11:2] == 10'h200;
    endsequence
    AST_ZERO_WAIT: assert property (psel && !penable |=> pready && penable)
        else $error("no answer in first access cycle");
    AST_READY_ACCESS: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready outside first access cycle");
    AST_MASK_CLEAR: assert property (s_setup_wr ##[1:2] s_mask_rd |=> prdata[7:0] == 8'h00)
        else $error("select mask not cleared by setup write");
    AST_ROUTE_RSVD: assert property (rd_done && paddr[11:2] == 10'h204 |-> prdata[7:6] == 2'b11 && prdata[3:2] == 2'b11)
        else $error("route reserved bits not one");
    AST_FLAG_RSVD: assert property (rd_done && paddr[11:8] == 4'h9 && paddr[3:2] == 2'b11 |-> prdata[7:2] == 6'h00)
        else $error("flag reserved bits not zero");
    AST_EVENT_ROUTE: assert property ((ev != 2'h0 && ev != ck && !pin_oe_n[ev_port][7]) [*2]
        |-> pin_out[ev_port][7] == $past(event_ch0)) else $error("event not on routed pin");
    AST_CLOCK_ROUTE: assert property ((ck != 2'h0 && !pin_oe_n[ck_port][7]) [*3]
        |-> pin_out[ck_port][7] != $past(pin_out[ck_port][7])) else $error("clock not on routed pin");
    AST_OE_BY_WRITE: assert property ($changed(pin_oe_n) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("direction changed without a write");
endmodule // pcva_port_cfg_chk
bind pcva_port_cfg pcva_port_cfg_chk i_pcva_port_cfg_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .event_ch0(event_ch0), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
`default_nettype wire

/* pcva_port_cfg_tb.sv */
// self-checking testbench for the port configuration and alias block
`timescale 1ns/1ps
`default_nettype none
module pcva_port_cfg_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, event_ch0 = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr;
    logic [15:0][7:0] pin_in = '0, pin_out, pin_oe_n;
    logic [32:0] q [$];
    logic [32:0] mon_e;
    logic [7:0] sm [16][8] = '{default: 8'h00};
    logic [7:0] dm [16] = '{default: 8'h00}, om [16] = '{default: 8'h00};
    int err_count = 0, checked = 0, seed = 91;
    pcva_port_cfg i_pcva_port_cfg (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .event_ch0(event_ch0), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    always #25 pclk = ~pclk;
    task automatic results();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [32:0] e);
        int n;
        q.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 33'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        bus(a, 1'b0, 8'h00, {25'h0, d});
    endtask
    function automatic logic [11:0] pa(input int p, input int o);
        return 12'(p * 128 + o);
    endfunction
    function automatic logic [11:0] va(input int v, input int r);
        return 12'(2304 + v * 16 + r * 4);
    endfunction
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            mon_e = q.pop_front();
            chk("pslverr", {31'h0, pslverr}, {31'h0, mon_e[32]});
            if (!pwrite) chk("prdata", prdata, mon_e[31:0]);
        end
    end
    initial begin
        #500000;
        err_count++;
        results();
    end
    initial begin
        int p, c, o, hv;
        logic [7:0] d, m, v;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h800, 8'h00);
        rd(12'h808, 8'h00);
        rd(12'h810, 8'hcc);
        bus(12'h804, 1'b1, 8'h5a, 33'h1_0000_0000);
        bus(12'h804, 1'b0, 8'h00, 33'h1_0000_0000);
        p = $unsigned($random(seed)) % 16;
        for (int k = 0; k < 3; k++) begin
            m = 8'($random(seed));
            c = $unsigned($random(seed)) % 8;
            m[c] = k[0];
            v = 8'($random(seed));
            wr(12'h800, m);
            wr(pa(p, 64 + 4 * c), v);
            rd(12'h800, 8'h00);
            for (int i = 0; i < 8; i++) if (m[i] || i == c) sm[p][i] = v;
            for (int i = 0; i < 8; i++) rd(pa(p, 64 + 4 * i), sm[p][i]);
            rd(12'h800, 8'h00);
        end
        for (c = 0; c < 16; c++) begin
            hv = c < 8 ? 1 : 3;
            o = 15 - c;
            d = 8'($random(seed));
            wr(c < 8 ? 12'h808 : 12'h80c, {c[3:0], o[3:0]});
            rd(c < 8 ? 12'h808 : 12'h80c, {c[3:0], o[3:0]});
            wr(va(hv, 0), d);
            dm[c] = d;
            rd(pa(c, 0), d);
            wr(va(hv - 1, 1), ~d);
            om[o] = ~d;
            rd(pa(o, 16), ~d);
        end
        for (int i = 0; i < 16; i++) begin
            chk("oe_n", {24'h0, pin_oe_n[i]}, {24'h0, ~dm[i]});
            chk("out", {24'h0, pin_out[i]}, {24'h0, om[i]});
        end
        wr(12'h808, {4'h0, p[3:0]});
        for (int i = 0; i < 16; i++) pin_in[i] <= 8'($random(seed));
        repeat (3) @(posedge pclk);
        for (int i = 0; i < 8; i++) d[i] = pin_in[p][i] & (sm[p][i][2:0] != 3'h7);
        rd(va(0, 2), d);
        wr(pa(p, 40), 8'h01);
        wr(pa(p, 44), 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(pa(p, 64), 8'(s));
            pin_in[p][0] <= 1'b1;
            repeat (3) @(posedge pclk);
            wr(va(0, 3), 8'hff);
            rd(va(0, 3), 8'h00);
            pin_in[p][0] <= 1'b0;
            repeat (3) @(posedge pclk);
            rd(va(0, 3), {7'h0, s != 1});
            wr(pa(p, 48), 8'h03);
            pin_in[p][0] <= 1'b1;
            repeat (3) @(posedge pclk);
            rd(va(0, 3), {7'h0, s != 2});
        end
        for (int i = 2; i < 5; i++) begin
            wr(pa(i, 0), 8'h80);
            wr(pa(i, 16), 8'h00);
        end
        for (int e = 1; e < 4; e++) begin
            wr(12'h810, 8'(e * 16));
            rd(12'h810, 8'(e * 16) | 8'hcc);
            event_ch0 <= 1'b1;
            repeat (3) @(posedge pclk);
            chk("event pin", {29'h0, pin_out[4][7], pin_out[3][7], pin_out[2][7]}, 32'(1 << (e - 1)));
            event_ch0 <= 1'b0;
            wr(12'h810, 8'(e * 17));
            @(posedge pclk);
            v[0] = pin_out[e + 1][7];
            @(posedge pclk);
            chk("clock pin", {31'h0, pin_out[e + 1][7]}, {31'h0, ~v[0]});
            wr(pa(e + 1, 0), 8'h00);
            repeat (2) begin
                @(posedge pclk);
                chk("input pin", {31'h0, pin_out[e + 1][7]}, 32'h0);
            end
            wr(pa(e + 1, 0), 8'h80);
        end
        results();
    end
endmodule // pcva_port_cfg_tb
`default_nettype wire
